// ==== logic/pmbc_top.sv ====
// power-mode sequencer, key registers and program bank select with an avalon-mm slave
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/100ps
`include "pmbc_defines.svh"
module pmbc_top #(
	parameter int unsigned BANK_BITS = 2,
	parameter int unsigned PORTA_W   = 8,
	parameter int unsigned WAKE_HOLD = `PMBC_WAKE_HOLD_CYC,
	parameter int unsigned WDT_LIMIT = `PMBC_WDT_CYC
) (
	// clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rstn,
	// avalon-mm slave
	input  wire logic [7:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	// option word, supply monitor and wake pins
	input  wire logic [7:0]             cfg_option,
	input  wire logic                   supply_low,
	input  wire logic [PORTA_W-1:0]     port_a,
	// system controls
	output logic                        sys_reset_req,
	output logic                        sys_clk_run,
	output logic                        cpu_hold,
	output logic                        lvr_active,
	output logic                        io_hold,
	output logic                        io_float,
	output logic                        io_input_en,
	output logic                        osc_internal,
	// program bank and power mode
	output logic [BANK_BITS-1:0]        rom_bank,
	output logic [BANK_BITS+14:0]       rom_base,
	output pmbc_pkg::pmbc_mode_type     pwr_mode
);
	import pmbc_pkg::*;

	localparam int unsigned HOLD_W = $clog2(WAKE_HOLD + 1);
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(WAKE_HOLD - 1);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		pmbc_mode_type        mode;
		logic                 waitreq;
		logic [31:0]          rdata;
		logic [BANK_BITS-1:0] bank;
		logic [PORTA_W-1:0]   porta_ref;
		logic [HOLD_W-1:0]    hold_cnt;
		logic                 sys_rst;
		logic                 clk_run;
		logic                 cpu_hold;
		logic                 lvr_act;
		logic                 io_hold;
		logic                 io_float;
		logic                 io_in_en;
		logic                 osc_int;
		logic                 wd_clear;
		logic                 wd_en;
	} pmbc_state_type;

	localparam pmbc_state_type ST_RST = '{
		mode:     PMBC_RUN,
		waitreq:  1'b1,
		bank:     BANK_BITS'(`PMBC_BANK_RST),
		clk_run:  1'b1,
		io_in_en: 1'b1,
		default:  '0
	};

	pmbc_state_type st_r;
	pmbc_state_type st_nxt;

	pmbc_wdog_if wd ();

	logic [5:0] idx;
	logic       wr_fire;
	logic [7:0] wbyte;
	logic       awake_mode;

	// byte address to register index; each register is one aligned word
	function automatic logic [5:0] word_index(input logic [7:0] addr);
		word_index = addr[7:2];
	endfunction

	assign idx        = word_index(avs_address);
	assign wbyte      = avs_writedata[7:0];
	// a write lands on the edge where waitrequest is seen low
	assign wr_fire    = avs_write && !st_r.waitreq && avs_byteenable[0];
	assign awake_mode = (st_r.mode == PMBC_RUN) || (st_r.mode == PMBC_WAKE);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt = st_r;
		st_nxt.sys_rst = 1'b0;
		st_nxt.wd_clear = 1'b0;

		// bus: one cycle of waitrequest low per request, read data captured with it
		if (st_r.waitreq && (avs_read || avs_write)) begin
			st_nxt.waitreq = 1'b0;
			case (word_index(avs_address))
				`PMBC_IDX_BANK: begin
					st_nxt.rdata = 32'(st_r.bank); // [RQ16] [RQ17]
				end
				`PMBC_IDX_STATUS: begin
					st_nxt.rdata = 32'(st_r.mode);
				end
				default: begin
					st_nxt.rdata = '0;
				end
			endcase
		end else begin
			st_nxt.waitreq = 1'b1;
		end

		case (st_r.mode)
			PMBC_RUN: begin
				if (supply_low) begin
					st_nxt.mode = PMBC_FREEZE; // [RQ8] [RQ9]
					st_nxt.sys_rst = 1'b1; // [RQ10]
				end else begin
					if (wr_fire) begin
						case (idx)
							`PMBC_IDX_BANK: begin
								st_nxt.bank = wbyte[BANK_BITS-1:0]; // [RQ16] [RQ17]
							end
							`PMBC_IDX_SLEEP: begin
								if (wbyte == `PMBC_SLEEP_KEY) begin
									st_nxt.mode = PMBC_SLEEP; // [RQ1] [RQ8]
									st_nxt.porta_ref = port_a; // [RQ20]
								end else begin
									st_nxt.sys_rst = 1'b1; // [RQ2]
								end
							end
							`PMBC_IDX_WDOG: begin
								if (wbyte == `PMBC_WDOG_KEY) begin
									st_nxt.wd_clear = 1'b1; // [RQ3]
								end else begin
									st_nxt.sys_rst = 1'b1; // [RQ3]
								end
							end
							default: begin
							end
						endcase
					end
					if (wd.timeout) begin
						st_nxt.mode = PMBC_RUN;
						st_nxt.sys_rst = 1'b1;
					end
				end
			end
			PMBC_SLEEP: begin
				// supply monitor is ignored here
				if (port_a != st_r.porta_ref) begin
					st_nxt.mode = PMBC_WAKE; // [RQ6] [RQ20]
					st_nxt.hold_cnt = '0;
				end
			end
			PMBC_WAKE: begin
				if (supply_low) begin
					st_nxt.mode = PMBC_FREEZE; // [RQ9]
					st_nxt.sys_rst = 1'b1; // [RQ10]
				end else if (st_r.hold_cnt == HOLD_LAST) begin
					st_nxt.mode = PMBC_RUN; // [RQ7]
				end else begin
					st_nxt.hold_cnt = st_r.hold_cnt + 1'b1; // [RQ7]
				end
			end
			PMBC_FREEZE: begin
				// only rstn (power-up or external reset) leaves this mode
				st_nxt.mode = PMBC_FREEZE; // [RQ13]
			end
			default: begin
				st_nxt.mode = PMBC_RUN;
			end
		endcase

		// any reset event returns the bank and restarts the watchdog
		if (st_nxt.sys_rst) begin
			st_nxt.bank = BANK_BITS'(`PMBC_BANK_RST); // [RQ10] [RQ16]
			st_nxt.wd_clear = 1'b1; // [RQ19]
		end

		// mode- and option-derived controls
		st_nxt.clk_run  = (st_nxt.mode == PMBC_RUN) || (st_nxt.mode == PMBC_WAKE); // [RQ4] [RQ11]
		st_nxt.cpu_hold = (st_nxt.mode != PMBC_RUN); // [RQ7] [RQ11]
		st_nxt.lvr_act  = st_nxt.clk_run; // [RQ5] [RQ12]
		st_nxt.io_hold  = (st_nxt.mode == PMBC_SLEEP); // [RQ5]
		st_nxt.io_float = (st_nxt.mode == PMBC_FREEZE); // [RQ12]
		st_nxt.io_in_en = (st_nxt.mode != PMBC_FREEZE); // [RQ12]
		st_nxt.wd_en    = (st_nxt.mode == PMBC_RUN) && cfg_option[`PMBC_CFG_WDT]; // [RQ14]
		st_nxt.osc_int  = cfg_option[`PMBC_CFG_OSC]; // [RQ18]
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// watchdog

	assign wd.clear  = st_r.wd_clear;
	assign wd.enable = st_r.wd_en;

	pmbc_wdog #(
		.LIMIT (WDT_LIMIT)
	) u_wdog (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.wd      (wd)
	);

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign avs_readdata    = st_r.rdata;
	assign avs_waitrequest = st_r.waitreq;
	assign sys_reset_req   = st_r.sys_rst;
	assign sys_clk_run     = st_r.clk_run;
	assign cpu_hold        = st_r.cpu_hold;
	assign lvr_active      = st_r.lvr_act;
	assign io_hold         = st_r.io_hold;
	assign io_float        = st_r.io_float;
	assign io_input_en     = st_r.io_in_en;
	assign osc_internal    = st_r.osc_int;
	assign rom_bank        = st_r.bank;
	// each bank covers a 32K window of the program space
	assign rom_base        = {st_r.bank, `PMBC_BANK_SPAN_BITS'(0)}; // [RQ15]
	assign pwr_mode        = st_r.mode;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	logic        run_quiet;
	logic [31:0] wake_len;

	assign run_quiet = st_r.mode == PMBC_RUN && !supply_low && !wd.timeout && wr_fire;

	// independent count of cycles spent holding after wake-up
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wake_len <= '0;
		end else if (st_r.mode == PMBC_WAKE) begin
			wake_len <= wake_len + 32'h1;
		end else begin
			wake_len <= '0;
		end
	end

	sequence key_sleep_s;
		run_quiet && idx == `PMBC_IDX_SLEEP && wbyte == `PMBC_SLEEP_KEY;
	endsequence

	sequence pin_change_s;
		pwr_mode == PMBC_SLEEP && port_a != st_r.porta_ref;
	endsequence

	// first hold cycle: cpu held, clock back, pins released, count from zero
	sequence wake_begin_s;
		pwr_mode == PMBC_WAKE && cpu_hold && sys_clk_run && !io_hold && st_r.hold_cnt == '0;
	endsequence

	bus_answer_a: assert property ( // bus slave
		st_r.waitreq && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest not low for exactly one cycle");

	sleep_entry_a: assert property ( // [RQ1] [RQ20]
		key_sleep_s |=> pwr_mode == PMBC_SLEEP && io_hold && st_r.porta_ref == $past(port_a))
		else $error("key write did not enter sleep");

	bad_key_a: assert property ( // [RQ2]
		run_quiet && idx == `PMBC_IDX_SLEEP && wbyte != `PMBC_SLEEP_KEY
		|=> sys_reset_req && pwr_mode == PMBC_RUN ##1 !sys_reset_req)
		else $error("bad sleep key did not give a one-cycle reset");

	wdog_key_a: assert property ( // [RQ3]
		run_quiet && idx == `PMBC_IDX_WDOG |=> wd.clear && (sys_reset_req == ($past(wbyte) != `PMBC_WDOG_KEY)))
		else $error("watchdog key write handled wrongly");

	sleep_gate_a: assert property ( // [RQ4] [RQ5]
		pwr_mode == PMBC_SLEEP |-> !sys_clk_run && !lvr_active && io_hold && !io_float)
		else $error("sleep outputs wrong");

	sleep_no_lvr_a: assert property ( // [RQ5] [RQ8]
		pwr_mode == PMBC_SLEEP && port_a == st_r.porta_ref |=> pwr_mode == PMBC_SLEEP)
		else $error("sleep left without a pin change");

	pin_wake_a: assert property ( // [RQ6]
		pin_change_s |=> wake_begin_s)
		else $error("pin change did not start the wake hold");

	wake_hold_a: assert property ( // [RQ7]
		pwr_mode == PMBC_WAKE ##1 pwr_mode == PMBC_RUN |-> $past(wake_len) == 32'(WAKE_HOLD - 1))
		else $error("wake hold length differs from the set count");

	freeze_entry_a: assert property ( // [RQ9] [RQ10]
		awake_mode && supply_low |=> pwr_mode == PMBC_FREEZE && sys_reset_req && rom_bank == '0 && wd.clear)
		else $error("supply low did not freeze and reset");

	freeze_outputs_a: assert property ( // [RQ11] [RQ12]
		pwr_mode == PMBC_FREEZE |-> !sys_clk_run && cpu_hold && io_float && !io_input_en && !lvr_active)
		else $error("freeze outputs wrong");

	freeze_stays_a: assert property ( // [RQ13]
		pwr_mode == PMBC_FREEZE |=> pwr_mode == PMBC_FREEZE && !sys_reset_req)
		else $error("freeze released without reset");

	freeze_wdog_a: assert property ( // [RQ14]
		pwr_mode == PMBC_FREEZE |-> !wd.enable && !wd.timeout)
		else $error("watchdog active in freeze");

	bank_write_a: assert property ( // [RQ16] [RQ17]
		run_quiet && idx == `PMBC_IDX_BANK |=> rom_bank == $past(wbyte[BANK_BITS-1:0]) ##1 $stable(rom_bank))
		else $error("bank write not stored");

	reset_wdog_a: assert property ( // [RQ19]
		sys_reset_req |-> wd.clear)
		else $error("reset did not clear the watchdog");
endmodule

// ==== shared/pmbc_defines.svh ====
// register map, field positions, keys and counts of the power-mode and bank control block
//
// How it works
// RQ1 - writing the key to the sleep key register enters SLEEP
// RQ2 - any other value written there requests a full system reset
// RQ3 - the key written to the watchdog key register clears it, other values reset
// RQ4 - in SLEEP every system clock, clock generation included, is gated off
// RQ5 - in SLEEP the low-voltage reset is off, RAM and pins keep their state
// RQ6 - any change on a port A pin ends SLEEP
// RQ7 - after wake-up the CPU stays held for 65536 system clock cycles
// RQ8 - SLEEP only by the key write, FREEZE automatically on supply low; the code ignores supply low in SLEEP
// RQ9 - a supply-low report from the monitor enters FREEZE; the code enters it from RUN and WAKE only, not from SLEEP
// RQ10 - the low-voltage event resets all functions to their initial state
// RQ11 - in FREEZE the system clock and CPU stop, RAM is kept
// RQ12 - in FREEZE all pins float with inputs off, low-voltage reset off
// RQ13 - FREEZE is left only by power-up or external reset
// RQ14 - the watchdog neither counts nor resets during FREEZE
// RQ15 - program memory is split in 32K banks, up to four of them
// RQ16 - bank number in bits 1:0, reserved bits above, resets to 0
// RQ17 - two-bank builds keep only bit 0 of the bank number
// RQ18 - bit 0 of the option word picks crystal or internal oscillator
// RQ19 - every reset event also clears and restarts the watchdog
// RQ20 - port A is latched at SLEEP entry, a mismatch wakes the device
`ifndef PMBC_DEFINES_SVH
`define PMBC_DEFINES_SVH

`define PMBC_IDX_BANK       6'h10
`define PMBC_IDX_SLEEP      6'h12
`define PMBC_IDX_WDOG       6'h20
`define PMBC_IDX_STATUS     6'h30
`define PMBC_SLEEP_KEY      8'hAA
`define PMBC_WDOG_KEY       8'hAA
`define PMBC_BANK_RST       8'h00
`define PMBC_BANK_SPAN_BITS 15
`define PMBC_CFG_OSC        0
`define PMBC_CFG_WDT        2
`define PMBC_WAKE_HOLD_CYC  32'h0001_0000
`define PMBC_WDT_CYC        32'h0010_0000

`endif

// ==== shared/pmbc_pkg.sv ====
// types shared by the power-mode and bank control block
package pmbc_pkg;

	typedef enum logic [1:0] {
		PMBC_RUN    = 2'b00,
		PMBC_SLEEP  = 2'b01,
		PMBC_WAKE   = 2'b10,
		PMBC_FREEZE = 2'b11
	} pmbc_mode_type;

endpackage

// ==== shared/pmbc_wdog_if.sv ====
// link between the mode controller and its watchdog counter
`timescale 1ns/100ps
interface pmbc_wdog_if;
	logic clear;
	logic enable;
	logic timeout;

	modport ctrl (output clear, output enable, input timeout);
	modport wdog (input clear, input enable, output timeout);
endinterface

// ==== logic/pmbc_wdog.sv ====
// watchdog counter: counts while enabled, pulses timeout at the limit
`timescale 1ns/100ps
`include "pmbc_defines.svh"
module pmbc_wdog #(
	parameter int unsigned LIMIT = `PMBC_WDT_CYC
) (
	// clock and reset
	input wire logic  ref_clk,
	input wire logic  rstn,
	// controller side
	pmbc_wdog_if.wdog wd
);
	import pmbc_pkg::*;

	localparam int unsigned CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          timeout;
	} pmbc_wdst_type;

	pmbc_wdst_type st_r;
	pmbc_wdst_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.timeout = 1'b0;
		if (wd.clear) begin
			st_nxt.cnt = '0; // [RQ19]
		end else if (wd.enable) begin
			if (st_r.cnt == LAST) begin
				st_nxt.cnt = '0;
				st_nxt.timeout = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wd.timeout = st_r.timeout;

	stall_no_count_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RQ14]
		!wd.enable && !wd.clear |=> st_r.cnt == $past(st_r.cnt) && !st_r.timeout)
		else $error("watchdog moved while disabled");
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the power-mode and bank control block
`timescale 1ns/100ps
module tb_top;
	import pmbc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] ST_RUN    = 8'h29;
	localparam logic [7:0] ST_SLEEP  = 8'h55;
	localparam logic [7:0] ST_WAKE   = 8'hB9;
	localparam logic [7:0] ST_FREEZE = 8'hD2;

	logic                ref_clk;
	logic                rstn;
	logic [7:0]          avs_address;
	logic                avs_read;
	logic                avs_write;
	logic [31:0]         avs_writedata;
	logic [3:0]          avs_byteenable;
	logic [31:0]         avs_readdata;
	logic                avs_waitrequest;
	logic [7:0]          cfg_option;
	logic                supply_low;
	logic [7:0]          port_a;
	logic                sys_reset_req;
	logic                sys_clk_run;
	logic                cpu_hold;
	logic                lvr_active;
	logic                io_hold;
	logic                io_float;
	logic                io_input_en;
	logic                osc_internal;
	logic [1:0]          rom_bank;
	logic [16:0]         rom_base;
	pmbc_mode_type       pwr_mode;
	logic [7:0]          st;
	logic [31:0]         q;
	int                  error_cnt;
	int                  checked;
	int                  pulses;
	int                  wake_cnt;
	int                  cyc_cnt;
	int                  p;

	// mode and all power controls packed for one compare
	assign st = {pwr_mode, sys_clk_run, cpu_hold, lvr_active, io_hold, io_float, io_input_en};

	pmbc_top #(
		.BANK_BITS (2),
		.PORTA_W   (8),
		.WAKE_HOLD (8),
		.WDT_LIMIT (32)
	) u_pmbc_top (
		.ref_clk         (ref_clk),
		.rstn            (rstn),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.cfg_option      (cfg_option),
		.supply_low      (supply_low),
		.port_a          (port_a),
		.sys_reset_req   (sys_reset_req),
		.sys_clk_run     (sys_clk_run),
		.cpu_hold        (cpu_hold),
		.lvr_active      (lvr_active),
		.io_hold         (io_hold),
		.io_float        (io_float),
		.io_input_en     (io_input_en),
		.osc_internal    (osc_internal),
		.rom_bank        (rom_bank),
		.rom_base        (rom_base),
		.pwr_mode        (pwr_mode)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	// outputs are settled at the falling edge
	always @(negedge ref_clk) begin
		cyc_cnt++;
		if (sys_reset_req === 1'b1) pulses++;
		if (pwr_mode === PMBC_WAKE) wake_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("counts: checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// request held until the edge that samples waitrequest low
	// no local limit: a slave that never answers is caught by the cycle ceiling
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		avs_address   <= a;
		avs_write     <= w;
		avs_read      <= !w;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(a, 1'b0, 32'h0000_0000, r);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0; avs_address = 8'h00; avs_read = 1'b0; avs_write = 1'b0;
		avs_writedata = 32'h0; avs_byteenable = 4'hF; cfg_option = 8'h00;
		supply_low = 1'b0; port_a = 8'h5A;
		error_cnt = 0; checked = 0; pulses = 0; wake_cnt = 0; cyc_cnt = 0;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		cyc(2);
		chk(32'(st), 32'(ST_RUN));
		chk(32'(rom_bank), 32'h0);
		rd(8'h40, q); chk(q, 32'h0);
		rd(8'h48, q); chk(q, 32'h0);
		rd(8'h80, q); chk(q, 32'h0);
		rd(8'hFC, q); chk(q, 32'h0);
		rd(8'hC0, q); chk(q, 32'h0);
		tdone("reset");

		// reserved bits set on every write
		for (int b = 0; b < 4; b++) begin
			wr(8'h40, 32'h0000_00FC | 32'(b));
			rd(8'h40, q); chk(q, 32'(b));
			chk(32'(rom_base), 32'(b) << 15);
		end
		avs_byteenable <= 4'hE;
		wr(8'h40, 32'h0000_0001);
		avs_byteenable <= 4'hF;
		rd(8'h40, q); chk(q, 32'h3);
		cfg_option <= 8'h01; cyc(2); chk(32'(osc_internal), 32'h1);
		cfg_option <= 8'h00; cyc(2); chk(32'(osc_internal), 32'h0);
		tdone("bank");

		p = pulses;
		wr(8'h48, 32'h0000_0055); cyc(2);
		chk(32'(pulses), 32'(p + 1));
		chk(32'(st), 32'(ST_RUN));
		chk(32'(rom_bank), 32'h0);
		tdone("sleep_wrong_key");

		cfg_option <= 8'h04;
		p = pulses;
		repeat (3) begin
			wr(8'h80, 32'h0000_00AA);
			cyc(20);
		end
		chk(32'(pulses), 32'(p));
		wr(8'h80, 32'h0000_003C); cyc(2);
		chk(32'(pulses), 32'(p + 1));
		cyc(22); chk(32'(pulses), 32'(p + 1));
		cyc(16); chk(32'(pulses), 32'(p + 2));
		cfg_option <= 8'h00;
		tdone("watchdog");

		wr(8'h40, 32'h0000_0001);
		p = pulses;
		wr(8'h48, 32'h0000_00AA); cyc(2);
		chk(32'(st), 32'(ST_SLEEP));
		supply_low <= 1'b1;
		wr(8'h40, 32'h0000_0003);
		wr(8'h48, 32'h0000_0011);
		cyc(8);
		chk(32'(st), 32'(ST_SLEEP));
		chk(32'(rom_bank), 32'h1);
		chk(32'(pulses), 32'(p));
		rd(8'hC0, q); chk(q, 32'h1);
		supply_low <= 1'b0;
		wake_cnt = 0;
		port_a <= 8'hDA;
		cyc(2); chk(32'(st), 32'(ST_WAKE));
		cyc(12); chk(32'(st), 32'(ST_RUN));
		chk(32'(wake_cnt), 32'h8);
		chk(32'(rom_bank), 32'h1);
		tdone("sleep");

		p = pulses;
		supply_low <= 1'b1; cyc(3);
		chk(32'(st), 32'(ST_FREEZE));
		chk(32'(pulses), 32'(p + 1));
		supply_low <= 1'b0;
		port_a <= 8'h00;
		cfg_option <= 8'h04;
		wr(8'h48, 32'h0000_00AA);
		cyc(60);
		chk(32'(st), 32'(ST_FREEZE));
		chk(32'(pulses), 32'(p + 1));
		rd(8'hC0, q); chk(q, 32'h3);
		cfg_option <= 8'h00;
		rstn <= 1'b0; cyc(2);
		rstn <= 1'b1; cyc(2);
		chk(32'(st), 32'(ST_RUN));
		rd(8'h40, q); chk(q, 32'h0);
		tdone("freeze");
		print_verdict();
	end
endmodule
